/* File: rtl/its_ct_if.sv */
// Signals between the cycle timer and the stamp logic
`timescale 1ns/10ps
`default_nettype none
interface its_ct_if;
	logic master;          // Device acts as cycle master
	logic tick;            // One count of the cycle offset
	logic rx_start;        // Decoded received cycle start
	logic [24:0] rx_time;  // Time carried by that start
	logic [24:0] now;      // Running cycle count and offset
	logic start;           // New isochronous cycle begins
	logic tx_start;        // Send a cycle start packet

	modport timer (
		input master, tick, rx_start, rx_time,
		output now, start, tx_start
	);
	modport user (
		output master, tick, rx_start, rx_time,
		input now, start, tx_start
	);
endinterface : its_ct_if
`default_nettype wire

/* File: rtl/its_cycle_timer.sv */
// Cycle timer: count above a modulo-3072 offset
`timescale 1ns/10ps
`default_nettype none
module its_cycle_timer (
	input wire logic mclk,
	input wire logic rst_n,
	its_ct_if.timer ct
);
	logic [11:0] ofs_q;   // Cycle offset
	logic [12:0] cnt_q;   // Cycle count
	logic start_q;        // Wrap seen this cycle
	logic tx_start_q;     // Cycle start packet request

	assign ct.now = {cnt_q, ofs_q};
	assign ct.start = start_q;
	assign ct.tx_start = tx_start_q;

	// Offset and count advance or reload
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ofs_q <= 12'h000;
			cnt_q <= 13'h0000;
		end else if (!ct.master && ct.rx_start) begin
			ofs_q <= ct.rx_time[11:0];
			cnt_q <= ct.rx_time[24:12];
		end else if (ct.tick) begin
			if (ofs_q == its_pkg::ITS_CYC_OFS_MAX) begin
				ofs_q <= 12'h000;
				if (cnt_q == its_pkg::ITS_CYC_CNT_MAX) begin
					cnt_q <= 13'h0000;
				end else begin
					cnt_q <= cnt_q + 13'h0001;
				end
			end else begin
				ofs_q <= ofs_q + 12'h001;
			end
		end
	end

	// New cycle marks and the master's start packet
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			start_q <= 1'b0;
			tx_start_q <= 1'b0;
		end else begin
			start_q <= (ct.tick && ofs_q == its_pkg::ITS_CYC_OFS_MAX)
				|| (!ct.master && ct.rx_start);
			tx_start_q <= ct.master && ct.tick
				&& ofs_q == its_pkg::ITS_CYC_OFS_MAX;
		end
	end
endmodule : its_cycle_timer
`default_nettype wire

/* File: rtl/its_pkg.sv */
// Shared constants and helpers for the isochronous time stamp unit
package its_pkg;

	// Register byte offsets
	localparam logic [7:0] ITS_OFF_CTRL = 8'h00;
	localparam logic [7:0] ITS_OFF_TX_OFS = 8'h04;
	localparam logic [7:0] ITS_OFF_RX_OFS = 8'h08;
	localparam logic [7:0] ITS_OFF_TX_STAMP = 8'h0c;
	localparam logic [7:0] ITS_OFF_RX_STAMP = 8'h10;
	localparam logic [7:0] ITS_OFF_TIMER = 8'h14;
	localparam logic [7:0] ITS_OFF_STATUS = 8'h18;

	// Control register field positions
	localparam int ITS_CTRL_TX_DV = 0;
	localparam int ITS_CTRL_RX_DV = 1;
	localparam int ITS_CTRL_RX_MPEG = 2;
	localparam int ITS_CTRL_RELEASE = 3;
	localparam int ITS_CTRL_AGE = 4;
	localparam int ITS_CTRL_FULL_ONLY = 5;
	localparam int ITS_CTRL_MASTER = 6;
	localparam int ITS_CTRL_W = 7;

	// Status register field positions
	localparam int ITS_ST_TX_PEND = 0;
	localparam int ITS_ST_RX_ARMED = 1;
	localparam int ITS_ST_MP_HELD = 2;
	localparam int ITS_ST_FSYNC = 3;

	// Reset values
	localparam logic [6:0] ITS_CTRL_RST = 7'h00;
	localparam logic [15:0] ITS_OFS_RST = 16'h0000;

	// Cycle timer limits
	localparam logic [11:0] ITS_CYC_OFS_MOD = 12'hc00;
	localparam logic [11:0] ITS_CYC_OFS_MAX = 12'hbff;
	localparam logic [12:0] ITS_CYC_CNT_MAX = 13'h1f3f;

	// Mode of the held MPEG2 entry
	typedef enum logic [2:0] {
		ITS_MP_IDLE = 3'b001,
		ITS_MP_HOLD = 3'b010,
		ITS_MP_DONE = 3'b100
	} its_mp_state_t;

	// Stamp plus offset with in-cycle wrap and 4-bit cycle carry
	function automatic logic [15:0] its_add_stamp(
		input logic [15:0] a,
		input logic [15:0] b
	);
		logic [15:0] sum;
		logic [11:0] low;
		logic [3:0] high;
		sum = a + b;
		low = sum[11:0];
		high = sum[15:12];
		if (low >= ITS_CYC_OFS_MOD) begin
			high = high + 4'h1;
			low = low - ITS_CYC_OFS_MOD;
		end
		return {high, low};
	endfunction : its_add_stamp

endpackage : its_pkg

/* File: rtl/its_stamp_top.sv */
// Time stamp unit for DV and MPEG2 isochronous streams
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Capture MPEG2 stamp, compare with cycle timer
// - Aging on: drop packets with expired stamps
// - Aging compares stamp plus receive offset
// - Latch cycle timer when frame sync rises
// - Stamp latched plus offset into next frame
// - Sixteen-bit stamp goes into SYT field
// - Low twelve bits in-cycle, top four cycles
// - Select first packet or first full packet
// - Cycle offset wraps at 3072, new cycle
// - Master sends cycle start; else takes received
// - In-cycle below 3072 keeps the sum
// - In-cycle 3072 up: carry, subtract 3072; a sum of 4096 up wraps at 4096 first (0bff plus 0bff gives 17fe)
// - Toggle frame sync out on stamp match
// - Output runs at half the source rate
// - DV data passes at once, no aging
// - DV receive stamp from SYT plus offset
// - MPEG2 held until stamp equals timer
// - Aged when stamp plus offset below time
// - Cycle count wraps to zero after 7999
module its_stamp_top (
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Cycle timer sources
	input wire logic cyc_tick,
	input wire logic cyc_rx_start,
	input wire logic [24:0] cyc_rx_time,
	output logic cyc_tx_start,
	// DV transmit
	input wire logic frame_sync_in,
	input wire logic tx_pkt_start,
	input wire logic tx_pkt_sof,
	input wire logic tx_pkt_full,
	output logic tx_syt_insert,
	output logic [15:0] tx_syt,
	// DV receive
	input wire logic rx_dv_valid,
	input wire logic [31:0] rx_dv_data,
	input wire logic rx_syt_valid,
	input wire logic [15:0] rx_syt,
	output logic app_dv_valid,
	output logic [31:0] app_dv_data,
	output logic frame_sync_out,
	// MPEG2 receive
	input wire logic rx_mp_valid,
	input wire logic [15:0] rx_mp_stamp,
	output logic rx_mp_ready,
	output logic app_mp_release,
	output logic app_mp_discard,
	output logic [15:0] app_mp_stamp
);
	// The cycle timer sits in its own module and talks to the
	// stamp logic through one interface. The top keeps plain
	// ports so the packet path and the application see ordinary
	// pins; only the timer bundle travels as an interface.
	its_ct_if ct ();

	logic [its_pkg::ITS_CTRL_W-1:0] ctrl_q;   // Mode control
	logic [15:0] tx_ofs_q;        // Transmit offset
	logic [15:0] rx_ofs_q;        // Receive offset
	logic fs_in_q;                // Previous frame sync level
	logic fs_rise;                // Frame sync went active
	logic [15:0] tx_latch_q;      // Timer at frame sync
	logic [15:0] tx_stamp_q;      // Computed transmit stamp
	logic tx_pend_q;              // Stamp waits for a packet
	logic tx_take;                // Packet takes the stamp
	logic [15:0] rx_stamp_q;      // Adjusted DV receive stamp
	logic rx_armed_q;             // Stamp not yet matched
	logic fs_out_q;               // Frame sync output level
	logic [15:0] now16;           // Timer in stamp form
	its_pkg::its_mp_state_t mp_q; // Held MPEG2 entry state
	logic [15:0] mp_stamp_q;      // Captured MPEG2 stamp
	logic [15:0] mp_aged;         // Stamp plus receive offset
	logic mp_match;               // Stamp equals timer
	logic mp_expired;             // Stamp has run out
	logic rel_q;                  // Release pulse
	logic dis_q;                  // Discard pulse
	logic [31:0] rdata_q;         // Read data register

	// Cycle timer in its own module
	assign ct.master = ctrl_q[its_pkg::ITS_CTRL_MASTER];
	assign ct.tick = cyc_tick;
	assign ct.rx_start = cyc_rx_start;
	assign ct.rx_time = cyc_rx_time;
	assign cyc_tx_start = ct.tx_start;

	its_cycle_timer u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.ct(ct.timer)
	);

	// Stamps carry only the low four bits of the cycle count, so
	// every compare below works on this sixteen-bit view. A match
	// repeats every sixteen cycles; a stamp must be armed within
	// that span of its due time or it matches on a wrong lap.
	// Four-bit cycle part above the offset
	assign now16 = {ct.now[15:12], ct.now[11:0]};

	// Writes land at the strobe edge and show the next cycle.
	// Writes to the stamp, timer and status words are dropped
	// so software cannot disturb running state.
	// Control and offset registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q <= its_pkg::ITS_CTRL_RST;
			tx_ofs_q <= its_pkg::ITS_OFS_RST;
			rx_ofs_q <= its_pkg::ITS_OFS_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				its_pkg::ITS_OFF_CTRL: begin
					ctrl_q <= reg_wdata[its_pkg::ITS_CTRL_W-1:0];
				end
				its_pkg::ITS_OFF_TX_OFS: begin
					tx_ofs_q <= reg_wdata[15:0];
				end
				its_pkg::ITS_OFF_RX_OFS: begin
					rx_ofs_q <= reg_wdata[15:0];
				end
				default: begin
					// Read-only or unmapped: write ignored
				end
			endcase
		end
	end

	// The read word is cleared when no read is strobed, so a
	// master that samples late sees zero rather than stale data.
	// Read data, valid the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				its_pkg::ITS_OFF_CTRL: begin
					rdata_q <= {25'h0000000, ctrl_q};
				end
				its_pkg::ITS_OFF_TX_OFS: begin
					rdata_q <= {16'h0000, tx_ofs_q};
				end
				its_pkg::ITS_OFF_RX_OFS: begin
					rdata_q <= {16'h0000, rx_ofs_q};
				end
				its_pkg::ITS_OFF_TX_STAMP: begin
					rdata_q <= {16'h0000, tx_stamp_q};
				end
				its_pkg::ITS_OFF_RX_STAMP: begin
					rdata_q <= {16'h0000, rx_stamp_q};
				end
				its_pkg::ITS_OFF_TIMER: begin
					rdata_q <= {7'h00, ct.now};
				end
				its_pkg::ITS_OFF_STATUS: begin
					rdata_q <= {28'h0000000, fs_out_q,
						mp_q == its_pkg::ITS_MP_HOLD, rx_armed_q, tx_pend_q};
				end
				default: begin
					rdata_q <= 32'h00000000;   // Unmapped reads zero
				end
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end
	assign reg_rdata = rdata_q;

	// The previous level resets low, the idle level of the pin,
	// so no false edge follows reset. The input is already in
	// the mclk domain, so no synchroniser is added here.
	// Frame sync edge detect; input is synchronous to mclk
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fs_in_q <= 1'b0;
		end else begin
			fs_in_q <= frame_sync_in;
		end
	end
	assign fs_rise = frame_sync_in && !fs_in_q
		&& ctrl_q[its_pkg::ITS_CTRL_TX_DV];

	// The sum is recomputed every cycle from the latched value,
	// so it is ready two cycles after the edge. A packet taking
	// the stamp sooner than that would carry the old sum; the
	// packet path must leave that gap after a frame sync.
	// Latch the timer at frame sync, compute the stamp after
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_latch_q <= 16'h0000;
			tx_stamp_q <= 16'h0000;
		end else begin
			if (fs_rise) begin
				tx_latch_q <= now16;
			end
			// Sum wraps in-cycle at 3072, or at 4096 first once it reaches 4096; cycle part mod 16
			tx_stamp_q <= its_pkg::its_add_stamp(tx_latch_q,
				tx_ofs_q);
		end
	end

	// With the full-only choice an empty start-of-frame packet
	// passes unstamped; the stamp waits for a full one.
	// Start-of-frame packet takes the stamp per selection
	assign tx_take = tx_pend_q && tx_pkt_start && tx_pkt_sof
		&& (tx_pkt_full
		|| !ctrl_q[its_pkg::ITS_CTRL_FULL_ONLY]);

	// If a frame sync and a qualifying packet meet in one cycle,
	// the packet carries the previous stamp and the flag stays
	// set, so the next start-of-frame packet gets the fresh one.
	// Pending flag; a new frame sync wins over the take
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_pend_q <= 1'b0;
		end else if (fs_rise) begin
			tx_pend_q <= 1'b1;
		end else if (tx_take) begin
			tx_pend_q <= 1'b0;
		end
	end

	// Stamp handed to the packet path for the SYT field
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_syt_insert <= 1'b0;
			tx_syt <= 16'h0000;
		end else begin
			tx_syt_insert <= tx_take;
			if (tx_take) begin
				tx_syt <= tx_stamp_q;
			end
		end
	end

	// Received DV words are never held against a stamp; they
	// pass through one register stage whether or not a stamp
	// is armed.
	// DV receive data goes straight to the application
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			app_dv_valid <= 1'b0;
			app_dv_data <= 32'h00000000;
		end else begin
			app_dv_valid <= rx_dv_valid
				&& ctrl_q[its_pkg::ITS_CTRL_RX_DV];
			if (rx_dv_valid) begin
				app_dv_data <= rx_dv_data;
			end
		end
	end

	// A new stamp that arrives in the cycle of a match replaces
	// the old one and stays armed; the toggle is then skipped so
	// the output never moves for a stamp already superseded.
	// DV receive stamp plus offset, armed until matched
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rx_stamp_q <= 16'h0000;
			rx_armed_q <= 1'b0;
		end else if (rx_syt_valid && ctrl_q[its_pkg::ITS_CTRL_RX_DV]) begin
			rx_stamp_q <= its_pkg::its_add_stamp(rx_syt,
				rx_ofs_q);
			rx_armed_q <= 1'b1;
		end else if (rx_armed_q && rx_stamp_q == now16) begin
			rx_armed_q <= 1'b0;
		end
	end

	// Each armed stamp toggles the output once; a frame-rate
	// source therefore yields a square wave at half its rate.
	// Toggle, not pulse, so output runs at half rate
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fs_out_q <= 1'b0;
		end else if (rx_armed_q && rx_stamp_q == now16
			&& !rx_syt_valid) begin
			fs_out_q <= !fs_out_q;
		end
	end
	assign frame_sync_out = fs_out_q;

	// Aging uses a plain unsigned compare on the sixteen-bit
	// stamp form. Near the sixteen-cycle lap a valid packet can
	// look expired; the receive offset should keep stamps well
	// clear of that edge.
	// MPEG2 stamp tests against the running timer
	assign mp_aged = its_pkg::its_add_stamp(mp_stamp_q,
		rx_ofs_q);
	assign mp_match = mp_stamp_q == now16;
	assign mp_expired = mp_aged < now16;
	assign rx_mp_ready = mp_q == its_pkg::ITS_MP_IDLE;

	// Only one packet is held at a time. Aging is tested before
	// release, so a stamp both due and expired is dropped. The
	// done state gives the application one quiet cycle before
	// the next packet may be taken.
	// Held entry: capture, release on match, drop on expiry
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mp_q <= its_pkg::ITS_MP_IDLE;
			mp_stamp_q <= 16'h0000;
			rel_q <= 1'b0;
			dis_q <= 1'b0;
		end else begin
			rel_q <= 1'b0;
			dis_q <= 1'b0;
			unique case (mp_q)
				its_pkg::ITS_MP_IDLE: begin
					if (rx_mp_valid && ctrl_q[its_pkg::ITS_CTRL_RX_MPEG]) begin
						mp_stamp_q <= rx_mp_stamp;
						mp_q <= its_pkg::ITS_MP_HOLD;
					end
				end
				its_pkg::ITS_MP_HOLD: begin
					if (ctrl_q[its_pkg::ITS_CTRL_AGE] && mp_expired) begin
						dis_q <= 1'b1;
						mp_q <= its_pkg::ITS_MP_DONE;
					end else if (!ctrl_q[its_pkg::ITS_CTRL_RELEASE]
						|| mp_match) begin
						rel_q <= 1'b1;
						mp_q <= its_pkg::ITS_MP_DONE;
					end
				end
				its_pkg::ITS_MP_DONE: begin
					mp_q <= its_pkg::ITS_MP_IDLE;     // One idle cycle
				end
				default: begin
					mp_q <= its_pkg::ITS_MP_IDLE;
				end
			endcase
		end
	end
	// Outcome pulses and the held stamp come straight from flops
	// so the application samples clean, glitch-free levels.
	assign app_mp_release = rel_q;
	assign app_mp_discard = dis_q;
	assign app_mp_stamp = mp_stamp_q;

endmodule : its_stamp_top
`default_nettype wire

/* File: verif/its_app_model.sv */
// Application side model: makes the frame sync input
`timescale 1ns/10ps
`default_nettype none
module its_app_model #(
	parameter int HALF = 8 // Scaled half period of the frame rate
) (
	input wire logic mclk,
	input wire logic frame_req,
	output logic frame_sync_in
);
	int cnt = 0; // Cycles left in the high half
	// Rise at the frame start, high for half the period
	always @(posedge mclk) begin
		if (frame_req) begin
			cnt <= HALF;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	assign frame_sync_in = cnt != 0;
endmodule : its_app_model
`default_nettype wire

/* File: verif/its_stamp_properties.sv */
// Port checker for the isochronous time stamp unit
`timescale 1ns/10ps
`default_nettype none
module its_stamp_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cyc_tick,
	input wire logic cyc_tx_start,
	input wire logic tx_pkt_start,
	input wire logic tx_pkt_sof,
	input wire logic tx_syt_insert,
	input wire logic [15:0] tx_syt,
	input wire logic rx_dv_valid,
	input wire logic [31:0] rx_dv_data,
	input wire logic app_dv_valid,
	input wire logic [31:0] app_dv_data,
	input wire logic frame_sync_out,
	input wire logic rx_mp_ready,
	input wire logic app_mp_release,
	input wire logic app_mp_discard,
	input wire logic [15:0] app_mp_stamp
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// DV words reach the application one cycle later, unchanged
	property p_dv_pass;
		rx_dv_valid |=> app_dv_valid && app_dv_data == $past(rx_dv_data);
	endproperty
	a_dv_pass: assert property (p_dv_pass) else $error("dv word lost");
	// Insert only follows a start-of-frame packet
	property p_ins_cause;
		tx_syt_insert |-> $past(tx_pkt_start) && $past(tx_pkt_sof);
	endproperty
	a_ins_cause: assert property (p_ins_cause) else $error("stray insert");
	// Insert is a single pulse
	property p_ins_pulse;
		tx_syt_insert |=> !tx_syt_insert;
	endproperty
	a_ins_pulse: assert property (p_ins_pulse) else $error("long insert");
	// Stamp only moves with an insert
	property p_syt_held;
		!tx_syt_insert |-> $stable(tx_syt);
	endproperty
	a_syt_held: assert property (p_syt_held) else $error("stamp moved");
	// No toggle in the cycle right after a toggle
	property p_fso_once;
		$changed(frame_sync_out) |=> $stable(frame_sync_out);
	endproperty
	a_fso_once: assert property (p_fso_once) else $error("double toggle");
	// Cycle start packets only follow an offset count
	property p_cts_cause;
		cyc_tx_start |-> $past(cyc_tick) || $past(cyc_tick, 2) ||
			$past(cyc_tick, 3);
	endproperty
	a_cts_cause: assert property (p_cts_cause) else $error("stray start");
	// After release or discard: one done cycle, then ready
	property p_mp_done;
		app_mp_release || app_mp_discard |-> !rx_mp_ready ##1 rx_mp_ready;
	endproperty
	a_mp_done: assert property (p_mp_done) else $error("bad done");
	// Never release and discard together
	property p_mp_excl;
		!(app_mp_release && app_mp_discard);
	endproperty
	a_mp_excl: assert property (p_mp_excl) else $error("both outcomes");
	// Held stamp stays put while the packet is held
	property p_mp_hold;
		!rx_mp_ready && !$past(rx_mp_ready) |-> $stable(app_mp_stamp);
	endproperty
	a_mp_hold: assert property (p_mp_hold) else $error("held stamp moved");
	c_rel: cover property (app_mp_release);
	c_dis: cover property (app_mp_discard);
	c_ins: cover property (tx_syt_insert);
	c_tog: cover property ($changed(frame_sync_out));
endmodule : its_stamp_props
bind its_stamp_top its_stamp_props its_stamp_props_inst (.mclk, .rst_n,
	.cyc_tick, .cyc_tx_start, .tx_pkt_start, .tx_pkt_sof, .tx_syt_insert,
	.tx_syt, .rx_dv_valid, .rx_dv_data, .app_dv_valid, .app_dv_data,
	.frame_sync_out, .rx_mp_ready, .app_mp_release, .app_mp_discard,
	.app_mp_stamp);
`default_nettype wire

/* File: verif/its_stamp_top_tb.sv */
// Self-checking bench for the isochronous time stamp unit
`timescale 1ns/10ps
`default_nettype none
module its_stamp_top_tb;
	logic mclk, rst_n, reg_wr, reg_rd, cyc_tick, cyc_rx_start, frame_req;
	logic tx_pkt_start, tx_pkt_sof, tx_pkt_full, rx_dv_valid, rx_syt_valid;
	logic rx_mp_valid, frame_sync_in, cyc_tx_start, tx_syt_insert, fso_q;
	logic app_dv_valid, frame_sync_out, rx_mp_ready, app_mp_release;
	logic app_mp_discard;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rx_dv_data, app_dv_data;
	logic [24:0] cyc_rx_time;
	logic [15:0] tx_syt, rx_syt, rx_mp_stamp, app_mp_stamp, t, o, e;
	int n_fail, tests_run, n_ins, n_rel, n_dis, n_tog, n_cts, cycles;
	// Rows: timer low bits, offset, expected stamp
	logic [47:0] rows [4] = '{48'h1100_0200_1300, 48'h2bff_0001_3000,
		48'hfb00_0200_0100, 48'h0bff_0bff_17fe};
	its_stamp_top its_stamp_top_inst (.mclk, .rst_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .cyc_tick, .cyc_rx_start, .cyc_rx_time,
		.cyc_tx_start, .frame_sync_in, .tx_pkt_start, .tx_pkt_sof,
		.tx_pkt_full, .tx_syt_insert, .tx_syt, .rx_dv_valid, .rx_dv_data,
		.rx_syt_valid, .rx_syt, .app_dv_valid, .app_dv_data, .frame_sync_out,
		.rx_mp_valid, .rx_mp_stamp, .rx_mp_ready, .app_mp_release,
		.app_mp_discard, .app_mp_stamp);
	its_app_model #(.HALF(8)) its_app_model_inst (.mclk, .frame_req,
		.frame_sync_in);
	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Count output events and cut a hang short
	always @(posedge mclk) begin
		cycles++;
		if (rst_n) begin
			n_ins += (tx_syt_insert === 1'b1);
			n_rel += (app_mp_release === 1'b1);
			n_dis += (app_mp_discard === 1'b1);
			n_cts += (cyc_tx_start === 1'b1);
			n_tog += (frame_sync_out !== fso_q);
		end
		fso_q = frame_sync_out;
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge mclk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, x);
	endtask : rd
	// Bits: full, sof, pkt, mp, load, tick, frame, syt; full and sof stay set, the rest pulse one cycle
	task pls(input logic [7:0] m, input logic [24:0] s);
		@(posedge mclk);
		{tx_pkt_full, tx_pkt_sof, tx_pkt_start, rx_mp_valid} <= m[7:4];
		{cyc_rx_start, cyc_tick, frame_req, rx_syt_valid} <= m[3:0];
		rx_dv_valid <= m[0];
		{cyc_rx_time, rx_syt, rx_mp_stamp} <= {s, s[15:0], s[15:0]};
		rx_dv_data <= {16'h0, s[15:0]};
		@(posedge mclk);
		{tx_pkt_start, rx_mp_valid, cyc_rx_start, cyc_tick} <= 4'h0;
		{frame_req, rx_syt_valid, rx_dv_valid} <= 3'h0;
	endtask : pls
	task summarize;
		if (n_fail == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	initial begin
		{reg_wr, reg_rd, cyc_tick, cyc_rx_start, frame_req, tx_pkt_start} = '0;
		{tx_pkt_sof, tx_pkt_full, rx_dv_valid, rx_syt_valid, rx_mp_valid} = '0;
		{reg_addr, reg_wdata, cyc_rx_time, rx_dv_data, rx_syt} = '0;
		{rx_mp_stamp, rst_n, fso_q} = '0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		wr(its_pkg::ITS_OFF_CTRL, 32'h3);
		// Stamp rows: transmit sum and receive match
		for (int k = 0; k < 4; k++) begin
			{t, o, e} = rows[k];
			wr(its_pkg::ITS_OFF_TX_OFS, {16'h0, o});
			wr(its_pkg::ITS_OFF_RX_OFS, {16'h0, o});
			pls(8'h08, {9'h0, t});
			rd(its_pkg::ITS_OFF_TIMER, {16'h0, t});
			pls(8'h02, 25'h0);
			pls(8'h01, {9'h0, t});
			wt(2);
			pls(8'h60, 25'h0);
			wt(2);
			chk(n_ins, k + 1);
			chk({16'h0, tx_syt}, {16'h0, e});
			chk(n_tog, k);
			chk(app_dv_data, {16'h0, t});
			pls(8'h08, {9'h0, e});
			wt(4);
			chk(n_tog, k + 1);
		end
		// Full-packet-only mode skips non-sof and empty packets
		wr(its_pkg::ITS_OFF_CTRL, 32'h21);
		pls(8'h02, 25'h0);
		wt(2);
		pls(8'ha0, 25'h0);
		pls(8'h60, 25'h0);
		wt(2);
		chk(n_ins, 4);
		pls(8'he0, 25'h0);
		wt(2);
		chk(n_ins, 5);
		chk({16'h0, tx_syt}, 32'h23fd);
		rd(its_pkg::ITS_OFF_TX_STAMP, 32'h23fd);
		rd(its_pkg::ITS_OFF_RX_STAMP, 32'h17fe);
		// MPEG2: plain pass, held until match, then aged
		wr(its_pkg::ITS_OFF_CTRL, 32'h04);
		pls(8'h10, 25'h1234);
		wt(3);
		chk(n_rel, 1);
		chk({16'h0, app_mp_stamp}, 32'h1234);
		wr(its_pkg::ITS_OFF_RX_OFS, 32'h10);
		wr(its_pkg::ITS_OFF_CTRL, 32'h1c);
		pls(8'h08, 25'h1008);
		pls(8'h10, 25'h1000);
		wt(6);
		chk(n_dis, 0);
		chk(n_rel, 1);
		rd(its_pkg::ITS_OFF_STATUS, 32'h4);
		pls(8'h08, 25'h1000);
		wt(4);
		chk(n_rel, 2);
		pls(8'h08, 25'h2000);
		pls(8'h10, 25'h1000);
		wt(4);
		chk(n_dis, 1);
		chk(n_rel, 2);
		// Cycle timer wraps; master sends starts, ignores loads
		wr(its_pkg::ITS_OFF_CTRL, 32'h0);
		pls(8'h08, {13'h1f3f, 12'hbff});
		pls(8'h04, 25'h0);
		rd(its_pkg::ITS_OFF_TIMER, 32'h0);
		pls(8'h08, {13'h5, 12'hbff});
		wr(its_pkg::ITS_OFF_CTRL, 32'h40);
		pls(8'h04, 25'h0);
		pls(8'h08, 25'h0);
		wr(its_pkg::ITS_OFF_TIMER, 32'hffff);
		rd(its_pkg::ITS_OFF_TIMER, 32'h6000);
		chk(n_cts, 1);
		rd(8'h40, 32'h0);
		wr(its_pkg::ITS_OFF_CTRL, 32'h0c);
		pls(8'h10, 25'h0fff);
		// Second reset in mid-run
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		wt(1);
		chk({tx_syt, 14'h0, frame_sync_out, rx_mp_ready}, 32'h1);
		rd(its_pkg::ITS_OFF_CTRL, 32'h0);
		rd(its_pkg::ITS_OFF_TX_OFS, 32'h0);
		summarize();
	end
endmodule : its_stamp_top_tb
`default_nettype wire
